// File: verilog/reference_clock_monitor.sv
// Summary of operation
// R1: Separate enabled loss detector per reference
// R2: Loss sets status and event flags
// R3: Loss flags routable to status pins
// R4: Reference rising edge restarts watchdog
// R5: Terminal count reached means reference lost
// R6: Sixteen-bit terminal count per reference
// R7: Watchdog steps every two system clocks
// R8: Loss flag follows watchdog, may chatter
// R9: Software keeps terminal count at least three
// R10: Software leaves margin for period variation
// R11: Enabled frequency monitor sets status, event
// R12: Frequency flags routable to four pins
// R13: Divider, 32-bit counter, 32-bit comparator
// R14: Divider and upper, lower limits programmable
// R15: Software keeps limit spread twenty or more
// R16: Automatic or manual selection by control bit
// R17: Switch depends on pin, bits, holdover
// R18: Pin input manual, output in automatic
// R19: Override uses choice bit, pin unaffected
// R20: Captured count outside limits flags frequency
// R21: Event flags sticky until software clears
`timescale 1ns/100ps
module reference_clock_monitor
   import refmon_pkg::*;
#(
   parameter int LOSS_W = WD_W,
   parameter int DIVIDER_W = DIV_W,
   parameter int COUNT_W = CNT_W
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   input wire logic i_first_reference_input,
   input wire logic i_second_reference_input,
   input wire logic i_reference_select_pin,
   input wire logic i_holdover,
   output logic o_reference_select_pin,
   output logic o_reference_select_oe_n,
   output logic o_active_reference,
   output logic [NUM_PINS-1:0] o_multipurpose_status_pins
);
   logic [CTRL_W-1:0] ctrl;
   logic [NUM_REFS-1:0] loss;
   logic [NUM_REFS-1:0] freq_out;
   logic [NUM_REFS-1:0] loss_event;
   logic [NUM_REFS-1:0] freq_event;
   logic [NUM_PINS*SRC_W-1:0] pin_map;
   logic [LOSS_W-1:0] loss_count [NUM_REFS];
   logic [DIVIDER_W-1:0] divider [NUM_REFS];
   logic [COUNT_W-1:0] low_limit [NUM_REFS];
   logic [COUNT_W-1:0] high_limit [NUM_REFS];
   logic tick;
   logic sel_sync1, sel_sync2;
   logic hold_sync1, hold_sync2;
   logic sm_choice;
   logic next_sm_choice;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
      hit = (a == ADDR_W'(off));
   endfunction

   function automatic logic pick(input logic [SRC_W-1:0] src,
                                 input logic [NUM_REFS-1:0] l,
                                 input logic [NUM_REFS-1:0] f);
      case (src)
         SRC_LOSS_A: pick = l[0];
         SRC_LOSS_B: pick = l[1];
         SRC_FREQ_A: pick = f[0];
         SRC_FREQ_B: pick = f[1];
         default: pick = 1'b0;
      endcase
   endfunction

   wire ref_pin [NUM_REFS];
   assign ref_pin[0] = i_first_reference_input;
   assign ref_pin[1] = i_second_reference_input;

   wire auto_sel = ctrl[CTRL_AUTO_SEL_POS];
   wire override = ctrl[CTRL_OVERRIDE_POS];
   wire choice = ctrl[CTRL_CHOICE_POS];
   wire [NUM_REFS-1:0] loss_en = ctrl[CTRL_LOSS_EN_POS +: NUM_REFS];
   wire [NUM_REFS-1:0] freq_en = ctrl[CTRL_FREQ_EN_POS +: NUM_REFS];
   wire [NUM_REFS-1:0] ref_bad = loss | freq_out;

   wire wr_ctrl = i_wr & hit(i_addr, ADDR_CTRL);
   wire wr_events = i_wr & hit(i_addr, ADDR_EVENTS);
   wire wr_pin_map = i_wr & hit(i_addr, ADDR_PIN_MAP);
   wire [NUM_REFS-1:0] wr_loss_count;
   wire [NUM_REFS-1:0] wr_divider;
   wire [NUM_REFS-1:0] wr_low;
   wire [NUM_REFS-1:0] wr_high;
   assign wr_loss_count = {i_wr & hit(i_addr, ADDR_LOSS_COUNT_B),
                           i_wr & hit(i_addr, ADDR_LOSS_COUNT_A)};
   assign wr_divider = {i_wr & hit(i_addr, ADDR_DIVIDER_B),
                        i_wr & hit(i_addr, ADDR_DIVIDER_A)};
   assign wr_low = {i_wr & hit(i_addr, ADDR_LOW_B), i_wr & hit(i_addr, ADDR_LOW_A)};
   assign wr_high = {i_wr & hit(i_addr, ADDR_HIGH_B), i_wr & hit(i_addr, ADDR_HIGH_A)};

   // Event clear is write-one-to-clear; a new event in the same cycle wins
   wire [NUM_REFS-1:0] loss_clr = wr_events ? i_wdata[STAT_LOSS_POS +: NUM_REFS] : '0;
   wire [NUM_REFS-1:0] freq_clr = wr_events ? i_wdata[STAT_FREQ_POS +: NUM_REFS] : '0;

   // Selection: holdover freezes the internal choice
   wire held = hold_sync2;
   wire sm_switch = ~held & ref_bad[sm_choice] & ~ref_bad[~sm_choice];
   wire auto_active = override ? choice : sm_choice;
   wire next_active = auto_sel ? auto_active : sel_sync2;

   wire [DATA_W-1:0] status_word;
   assign status_word = DATA_W'({held, sm_choice, o_active_reference, freq_out, loss});
   wire [DATA_W-1:0] event_word;
   assign event_word = DATA_W'({freq_event, loss_event});

   logic [DATA_W-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      case (i_addr)
         ADDR_CTRL: rd_mux = DATA_W'(ctrl);
         ADDR_STATUS: rd_mux = status_word;
         ADDR_EVENTS: rd_mux = event_word;
         ADDR_PIN_MAP: rd_mux = DATA_W'(pin_map);
         ADDR_LOSS_COUNT_A: rd_mux = DATA_W'(loss_count[0]);
         ADDR_LOSS_COUNT_B: rd_mux = DATA_W'(loss_count[1]);
         ADDR_DIVIDER_A: rd_mux = DATA_W'(divider[0]);
         ADDR_DIVIDER_B: rd_mux = DATA_W'(divider[1]);
         ADDR_LOW_A: rd_mux = DATA_W'(low_limit[0]);
         ADDR_LOW_B: rd_mux = DATA_W'(low_limit[1]);
         ADDR_HIGH_A: rd_mux = DATA_W'(high_limit[0]);
         ADDR_HIGH_B: rd_mux = DATA_W'(high_limit[1]);
         default: rd_mux = '0;
      endcase
   end

   // Half-rate enable for the watchdogs
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         tick <= 1'b0;
      end else begin
         tick <= ~tick; // [R7]
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ctrl <= CTRL_RESET;
         pin_map <= PIN_MAP_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl <= i_wdata[CTRL_W-1:0]; // [R1] [R11] [R16]
         end
         if (wr_pin_map) begin
            pin_map <= i_wdata[NUM_PINS*SRC_W-1:0]; // [R3] [R12]
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_REFS; g++) begin : chan
         always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               loss_count[g] <= LOSS_COUNT_RESET;
               divider[g] <= DIVIDER_RESET;
               low_limit[g] <= LOW_RESET;
               high_limit[g] <= HIGH_RESET;
            end else begin
               if (wr_loss_count[g]) begin
                  loss_count[g] <= i_wdata[LOSS_W-1:0]; // [R6]
               end
               if (wr_divider[g]) begin
                  divider[g] <= i_wdata[DIVIDER_W-1:0]; // [R14]
               end
               if (wr_low[g]) begin
                  low_limit[g] <= i_wdata[COUNT_W-1:0]; // [R14]
               end
               if (wr_high[g]) begin
                  high_limit[g] <= i_wdata[COUNT_W-1:0]; // [R14]
               end
            end
         end

         always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               loss_event[g] <= 1'b0;
               freq_event[g] <= 1'b0;
            end else begin
               loss_event[g] <= loss[g] | (loss_event[g] & ~loss_clr[g]); // [R2] [R21]
               freq_event[g] <= freq_out[g] | (freq_event[g] & ~freq_clr[g]); // [R11] [R21]
            end
         end

         ref_channel #(
            .WDW(LOSS_W),
            .DVW(DIVIDER_W),
            .CW(COUNT_W)
         ) u_chan (
            .i_mclk(i_mclk),
            .i_rst(i_rst),
            .i_ref(ref_pin[g]),
            .i_tick(tick),
            .i_loss_en(loss_en[g]),
            .i_freq_en(freq_en[g]),
            .i_loss_count(loss_count[g]),
            .i_divider(divider[g]),
            .i_low(low_limit[g]),
            .i_high(high_limit[g]),
            .o_loss(loss[g]),
            .o_freq_out(freq_out[g])
         );
      end

      for (g = 0; g < NUM_PINS; g++) begin : pins
         always_ff @(posedge i_mclk or posedge i_rst) begin
            if (i_rst) begin
               o_multipurpose_status_pins[g] <= 1'b0;
            end else begin
               o_multipurpose_status_pins[g] <=
                  pick(pin_map[g*SRC_W +: SRC_W], loss, freq_out); // [R3] [R12]
            end
         end
      end
   endgenerate

   // Pin inputs pass two flops before use
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sel_sync1 <= 1'b0;
         sel_sync2 <= 1'b0;
         hold_sync1 <= 1'b0;
         hold_sync2 <= 1'b0;
      end else begin
         sel_sync1 <= i_reference_select_pin;
         sel_sync2 <= sel_sync1;
         hold_sync1 <= i_holdover;
         hold_sync2 <= hold_sync1;
      end
   end

   // Minimal internal choice: leave a failed reference only for a healthy one
   always_comb begin
      next_sm_choice = sm_choice;
      if (sm_switch) begin
         next_sm_choice = ~sm_choice; // [R17]
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sm_choice <= 1'b0;
         o_active_reference <= 1'b0;
         o_reference_select_pin <= 1'b0;
         o_reference_select_oe_n <= 1'b1;
      end else begin
         sm_choice <= next_sm_choice;
         // Holdover keeps the active reference where it is
         if (!held) begin
            o_active_reference <= next_active; // [R16] [R17] [R19]
         end
         o_reference_select_pin <= sm_choice; // [R19]
         o_reference_select_oe_n <= ~auto_sel; // [R18]
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else begin
         o_rdata <= i_rd ? rd_mux : '0;
      end
   end
endmodule

// File: verilog/refmon_pkg.sv
package refmon_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int NUM_REFS = 2;
   localparam int NUM_PINS = 4;
   localparam int SRC_W = 3;
   localparam int WD_W = 16;
   localparam int DIV_W = 16;
   localparam int CNT_W = 32;
   // Register offsets (word index on the plain port)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_EVENTS = 4'h2;
   localparam logic [3:0] ADDR_PIN_MAP = 4'h3;
   localparam logic [3:0] ADDR_LOSS_COUNT_A = 4'h4;
   localparam logic [3:0] ADDR_LOSS_COUNT_B = 4'h5;
   localparam logic [3:0] ADDR_DIVIDER_A = 4'h6;
   localparam logic [3:0] ADDR_DIVIDER_B = 4'h7;
   localparam logic [3:0] ADDR_LOW_A = 4'h8;
   localparam logic [3:0] ADDR_LOW_B = 4'h9;
   localparam logic [3:0] ADDR_HIGH_A = 4'ha;
   localparam logic [3:0] ADDR_HIGH_B = 4'hb;
   // Control register fields
   localparam int CTRL_LOSS_EN_POS = 0;
   localparam int CTRL_FREQ_EN_POS = 2;
   localparam int CTRL_AUTO_SEL_POS = 4;
   localparam int CTRL_OVERRIDE_POS = 5;
   localparam int CTRL_CHOICE_POS = 6;
   localparam int CTRL_W = 7;
   // Status and event fields
   localparam int STAT_LOSS_POS = 0;
   localparam int STAT_FREQ_POS = 2;
   localparam int STAT_ACTIVE_POS = 4;
   localparam int STAT_SM_POS = 5;
   localparam int STAT_HOLD_POS = 6;
   // Pin map source codes
   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_LOSS_A = 3'h1;
   localparam logic [2:0] SRC_LOSS_B = 3'h2;
   localparam logic [2:0] SRC_FREQ_A = 3'h3;
   localparam logic [2:0] SRC_FREQ_B = 3'h4;
   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
   localparam logic [11:0] PIN_MAP_RESET = 12'h000;
   localparam logic [15:0] LOSS_COUNT_RESET = 16'hffff;
   localparam logic [15:0] DIVIDER_RESET = 16'h0001;
   localparam logic [31:0] LOW_RESET = 32'h00000000;
   localparam logic [31:0] HIGH_RESET = 32'hffffffff;
   // Watchdog steps once every this many system clocks
   localparam int WD_TICK_CYCLES = 2;
endpackage

// File: verilog/ref_channel.sv
`timescale 1ns/100ps
module ref_channel
   import refmon_pkg::*;
#(
   parameter int WDW = WD_W,
   parameter int DVW = DIV_W,
   parameter int CW = CNT_W
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ref,
   input wire logic i_tick,
   input wire logic i_loss_en,
   input wire logic i_freq_en,
   input wire logic [WDW-1:0] i_loss_count,
   input wire logic [DVW-1:0] i_divider,
   input wire logic [CW-1:0] i_low,
   input wire logic [CW-1:0] i_high,
   output logic o_loss,
   output logic o_freq_out
);
   logic sync1, sync2, sync3;
   logic [WDW-1:0] wd_cnt;
   logic [DVW-1:0] div_cnt;
   logic [CW-1:0] per_cnt;
   logic primed;

   wire rise = sync2 & ~sync3;
   wire wd_full = (wd_cnt >= i_loss_count);
   wire [DVW-1:0] div_term = (i_divider == '0) ? DVW'(1) : i_divider;
   wire div_edge = rise & (div_cnt >= div_term - DVW'(1));
   wire per_max = &per_cnt;
   wire per_bad = (per_cnt < i_low) | (per_cnt > i_high);

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
      end else begin
         sync1 <= i_ref;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Loss watchdog, steps at half the system rate
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         wd_cnt <= '0;
      end else if (!i_loss_en || rise) begin
         wd_cnt <= '0; // [R4]
      end else if (i_tick && !wd_full) begin
         wd_cnt <= wd_cnt + WDW'(1); // [R7]
      end
   end

   // No hysteresis: the flag tracks the timer, so it may chatter near the bound
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_loss <= 1'b0;
      end else begin
         o_loss <= i_loss_en & wd_full & ~rise; // [R5] [R6] [R8]
      end
   end

   // Frequency monitor: divider, period counter, comparator
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         div_cnt <= '0;
         per_cnt <= '0;
         primed <= 1'b0;
         o_freq_out <= 1'b0;
      end else if (!i_freq_en) begin
         div_cnt <= '0;
         per_cnt <= '0;
         primed <= 1'b0;
         o_freq_out <= 1'b0;
      end else begin
         if (rise) begin
            div_cnt <= div_edge ? '0 : div_cnt + DVW'(1); // [R13] [R14]
         end
         if (div_edge) begin
            per_cnt <= '0;
            primed <= 1'b1;
            // First window after enable is partial, so it is not judged
            if (primed) begin
               o_freq_out <= per_bad; // [R20]
            end
         end else begin
            if (!per_max) begin
               per_cnt <= per_cnt + CW'(1); // [R13]
            end
            // A missing edge would otherwise never be judged
            if (primed && per_cnt > i_high) begin
               o_freq_out <= 1'b1; // [R20]
            end
         end
      end
   end
endmodule

// File: tb/reference_clock_monitor_props.sv
`timescale 1ns/100ps
module refmon_props
   import refmon_pkg::*;
#(
   parameter int LOSS_W = WD_W
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic i_first_reference_input,
   input wire logic i_reference_select_pin,
   input wire logic i_holdover,
   input wire logic o_reference_select_oe_n,
   input wire logic o_active_reference,
   input wire logic [NUM_PINS-1:0] o_multipurpose_status_pins
);
   logic [CTRL_W-1:0] ctrl;
   logic [11:0] pmap;
   logic [LOSS_W-1:0] n_a;
   logic [3:0] age;
   logic [31:0] quiet;
   logic ref_q;
   logic from_edge;
   // Shadow settings; checks wait out the sync and output pipeline
   wire cfg_wr = i_wr && (i_addr == ADDR_CTRL || i_addr == ADDR_PIN_MAP
      || i_addr == ADDR_LOSS_COUNT_A);
   wire rise = i_first_reference_input && !ref_q;
   wire settled = age > 4'h5;
   wire watch = settled && ctrl[CTRL_LOSS_EN_POS] && pmap[2:0] == SRC_LOSS_A;
   wire manual = settled && !ctrl[CTRL_AUTO_SEL_POS] && !i_holdover;
   wire [31:0] lim = 32'(n_a) << 1;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ctrl <= CTRL_RESET;
         pmap <= PIN_MAP_RESET;
         n_a <= LOSS_W'(LOSS_COUNT_RESET);
         age <= 4'h0;
         quiet <= 32'h0;
         ref_q <= 1'b0;
         from_edge <= 1'b0;
      end else begin
         if (i_wr && i_addr == ADDR_CTRL) ctrl <= i_wdata[CTRL_W-1:0];
         if (i_wr && i_addr == ADDR_PIN_MAP) pmap <= i_wdata[11:0];
         if (i_wr && i_addr == ADDR_LOSS_COUNT_A) n_a <= i_wdata[LOSS_W-1:0];
         age <= cfg_wr ? 4'h0 : (settled ? age : age + 4'h1);
         ref_q <= i_first_reference_input;
         quiet <= (cfg_wr || rise) ? 32'h0 : quiet + 32'h1;
         if (cfg_wr || rise) from_edge <= !cfg_wr;
      end
   end
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data not zero outside read cycle");
   AST_SEL_DIR: assert property (
      settled |-> o_reference_select_oe_n == !ctrl[CTRL_AUTO_SEL_POS])
      else $error("select pin direction wrong");
   AST_MANUAL: assert property (
      (manual && $stable(i_reference_select_pin))[*6]
      |-> o_active_reference == i_reference_select_pin)
      else $error("manual reference not taken from pin");
   AST_OVERRIDE: assert property (
      (settled && ctrl[CTRL_AUTO_SEL_POS] && ctrl[CTRL_OVERRIDE_POS] && !i_holdover)[*4]
      |-> o_active_reference == ctrl[CTRL_CHOICE_POS])
      else $error("override choice not used");
   AST_PIN_IDLE: assert property (
      settled && pmap[11:9] == SRC_NONE |-> !o_multipurpose_status_pins[3])
      else $error("unassigned status pin active");
   AST_LOSS_OFF: assert property (
      settled && !ctrl[CTRL_LOSS_EN_POS] && pmap[2:0] == SRC_LOSS_A
      |-> !o_multipurpose_status_pins[0])
      else $error("disabled loss detector flags");
   AST_LOSS_SET: assert property (
      watch && quiet > lim + 32'ha |-> o_multipurpose_status_pins[0])
      else $error("loss not flagged after timeout");
   AST_LOSS_CLEAR: assert property (
      watch && from_edge && quiet >= 32'h8 && quiet + 32'h3 < lim
      |-> !o_multipurpose_status_pins[0])
      else $error("loss flagged before timeout");
endmodule
bind reference_clock_monitor refmon_props #(.LOSS_W(LOSS_W)) props_u (.i_mclk, .i_rst,
   .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_first_reference_input,
   .i_reference_select_pin, .i_holdover, .o_reference_select_oe_n, .o_active_reference,
   .o_multipurpose_status_pins);

// File: tb/ref_source_model.sv
`timescale 1ns/100ps
module ref_source_model #(
   parameter int HALF_A = 37,
   parameter int HALF_B = 41
) (
   input wire logic i_run_a,
   input wire logic i_run_b,
   input wire logic i_sel,
   input wire logic i_dev_sel,
   input wire logic i_dev_oe_n,
   output logic o_ref_a,
   output logic o_ref_b,
   output logic o_sel_wire
);
   // Odd half periods keep edges unrelated to the clock; a dead source stands low
   initial begin
      o_ref_a = 1'b0;
      forever #(HALF_A) o_ref_a = i_run_a && !o_ref_a;
   end
   initial begin
      o_ref_b = 1'b0;
      forever #(HALF_B) o_ref_b = i_run_b && !o_ref_b;
   end
   assign o_sel_wire = i_dev_oe_n ? i_sel : i_dev_sel;
endmodule

// File: tb/reference_clock_monitor_bench.sv
`timescale 1ns/100ps
module reference_clock_monitor_bench
   import refmon_pkg::*;
;
   logic i_mclk, i_rst, i_wr, i_rd, i_holdover;
   logic [ADDR_W-1:0] i_addr;
   logic [DATA_W-1:0] i_wdata, rdata;
   logic ref_a, ref_b, sel_wire, sel_out, oe_n, active, run_a, run_b, sel_lvl;
   logic [NUM_PINS-1:0] pins;
   int fail_count, n_compared;
   reference_clock_monitor dut_u (.i_mclk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
      .o_rdata(rdata), .i_first_reference_input(ref_a), .i_second_reference_input(ref_b),
      .i_reference_select_pin(sel_wire), .i_holdover, .o_reference_select_pin(sel_out),
      .o_reference_select_oe_n(oe_n), .o_active_reference(active),
      .o_multipurpose_status_pins(pins));
   ref_source_model src_u (.i_run_a(run_a), .i_run_b(run_b), .i_sel(sel_lvl),
      .i_dev_sel(sel_out), .i_dev_oe_n(oe_n), .o_ref_a(ref_a), .o_ref_b(ref_b),
      .o_sel_wire(sel_wire));
   initial begin
      i_mclk = 1'b0;
      forever #4 i_mclk = !i_mclk;
   end
   task automatic close_out();
      if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_mclk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m = '1);
      @(posedge i_mclk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask
   task automatic t_regs();
      rchk(ADDR_LOSS_COUNT_B, 32'hffff);
      rchk(ADDR_DIVIDER_B, 32'h1);
      rchk(ADDR_HIGH_A, 32'hffffffff);
      wr(ADDR_LOSS_COUNT_A, 32'h1234abcd);
      rchk(ADDR_LOSS_COUNT_A, 32'habcd);
      wr(ADDR_STATUS, 32'h7f);
      rchk(ADDR_STATUS, 32'h0);
      wr(4'hc, 32'h1);
      rchk(4'hc, 32'h0);
   endtask
   task automatic t_loss();
      wr(ADDR_PIN_MAP, {20'h0, SRC_FREQ_B, SRC_FREQ_A, SRC_LOSS_B, SRC_LOSS_A});
      wr(ADDR_LOSS_COUNT_A, 32'h8);
      wr(ADDR_LOSS_COUNT_B, 32'h8);
      wr(ADDR_CTRL, 32'h3);
      idle(40);
      chk(32'(pins), 32'h0);
      run_b <= 1'b0;
      idle(40);
      chk(32'(pins), 32'h2);
      run_a <= 1'b0;
      idle(40);
      chk(32'(pins), 32'h3);
      rchk(ADDR_STATUS, 32'h3, 32'hf);
      rchk(ADDR_EVENTS, 32'h3);
      run_a <= 1'b1;
      idle(30);
      chk(32'(pins), 32'h2);
      run_b <= 1'b1;
      idle(30);
      wr(ADDR_EVENTS, 32'h1);
      rchk(ADDR_EVENTS, 32'h2);
      wr(ADDR_EVENTS, 32'h2);
      wr(ADDR_CTRL, 32'h2);
      run_a <= 1'b0;
      idle(40);
      chk(32'(pins), 32'h0);
      run_a <= 1'b1;
   endtask
   task automatic t_freq();
      wr(ADDR_DIVIDER_A, 32'h8);
      wr(ADDR_DIVIDER_B, 32'h8);
      wr(ADDR_LOW_A, 32'h3c);
      wr(ADDR_LOW_B, 32'h3c);
      wr(ADDR_HIGH_A, 32'h64);
      wr(ADDR_HIGH_B, 32'h64);
      wr(ADDR_CTRL, 32'hf);
      idle(400);
      chk(32'(pins), 32'h0);
      wr(ADDR_HIGH_B, 32'h8c);
      wr(ADDR_LOW_B, 32'h78);
      idle(400);
      chk(32'(pins), 32'h8);
      wr(ADDR_LOW_A, 32'h14);
      wr(ADDR_HIGH_A, 32'h32);
      idle(400);
      chk(32'(pins), 32'hc);
      rchk(ADDR_STATUS, 32'hc, 32'hf);
      rchk(ADDR_EVENTS, 32'hc);
   endtask
   task automatic t_sel();
      wr(ADDR_CTRL, 32'h3);
      sel_lvl <= 1'b1;
      idle(8);
      chk(32'({oe_n, active}), 32'h3);
      wr(ADDR_CTRL, 32'h13);
      idle(8);
      chk(32'({oe_n, sel_out, active}), 32'h0);
      wr(ADDR_CTRL, 32'h73);
      idle(8);
      chk(32'({sel_out, active}), 32'h1);
      i_holdover <= 1'b1;
      run_a <= 1'b0;
      idle(40);
      chk(32'(sel_out), 32'h0);
      i_holdover <= 1'b0;
      idle(8);
      chk(32'(sel_out), 32'h1);
      wr(ADDR_CTRL, 32'h13);
      idle(8);
      chk(32'(active), 32'h1);
   endtask
   initial begin
      i_rst = 1'b1;
      i_addr = '0;
      i_wdata = '0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_holdover = 1'b0;
      run_a = 1'b1;
      run_b = 1'b1;
      sel_lvl = 1'b0;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      t_regs();
      t_loss();
      t_freq();
      t_sel();
      close_out();
   end
   // About 1600 clocks of tests; allow several times that
   initial begin
      #100000;
      fail_count++;
      close_out();
   end
endmodule
